// ### common/brake_pkg.sv
// shared constants and types of the holding-brake sequencer
package brake_pkg;
    // register byte offsets on the AHB-Lite slave
    localparam logic [11:0] ON_DELAY_OFS = 12'h000;
    localparam logic [11:0] OFF_DELAY_OFS = 12'h004;
    localparam logic [11:0] SPEED_THR_OFS = 12'h008;
    localparam logic [11:0] STATUS_OFS = 12'h00C;
    // reset values of the settings
    localparam logic [15:0] ON_DELAY_RST = 16'h0000;
    localparam logic [15:0] OFF_DELAY_RST = 16'h0000;
    localparam logic [15:0] SPEED_THR_RST = 16'h0000;
    // status field positions
    localparam int STAT_RELEASE_BIT = 0;
    localparam int STAT_SERVO_BIT = 1;
    localparam int STAT_BELOW_BIT = 2;
    localparam int STAT_STATE_LSB = 3;
    // delays count in milliseconds of the 40 MHz clock
    localparam int MS_NS = 1000000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int SETTING_W = 16;
    localparam int TICK_W = 16;

    typedef enum logic [1:0] {
        ENGAGED,
        ON_WAIT,
        RELEASED,
        OFF_WAIT
    } brake_state_e;
endpackage : brake_pkg

// ### common/brake_seq_if.sv
// timer and speed-compare signals between the sequencer and its helpers
`timescale 1ns/1ps
`default_nettype none
interface brake_seq_if;
    logic start;
    logic [15:0] setting;
    logic done;
    logic [15:0] speed;
    logic [15:0] threshold;
    logic below;

    modport seq (output start, output setting, input done,
                 output speed, output threshold, input below);
    modport timer (input start, input setting, output done);
    modport cmp (input speed, input threshold, output below);
endinterface : brake_seq_if
`default_nettype wire

// ### hw/brake_delay_timer.sv
// millisecond delay timer restarted by a start pulse
`timescale 1ns/1ps
`default_nettype none
module brake_delay_timer #(
    parameter int TICKS = brake_pkg::TICK_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    brake_seq_if.timer tif
);
    logic active;
    logic [15:0] tick_cnt;
    logic [15:0] ms_cnt;
    logic [15:0] target;

    // done stands while the elapsed milliseconds equal the latched target
    assign tif.done = active && (ms_cnt == target);

    // prescaler restarts on start so a delay of n is exactly n ms
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active <= 1'b0;
            tick_cnt <= 16'h0000;
            ms_cnt <= 16'h0000;
            target <= 16'h0000;
        end else if (tif.start) begin
            active <= 1'b1;
            tick_cnt <= 16'h0000;
            ms_cnt <= 16'h0000;
            target <= tif.setting;
        end else if (active && !tif.done) begin
            if (tick_cnt == 16'(TICKS - 1)) begin
                tick_cnt <= 16'h0000;
                ms_cnt <= ms_cnt + 16'h0001;
            end else begin
                tick_cnt <= tick_cnt + 16'h0001;
            end
        end
    end
endmodule : brake_delay_timer
`default_nettype wire

// ### hw/brake_speed_compare.sv
// registered comparison of motor speed against the zero-speed threshold
`timescale 1ns/1ps
`default_nettype none
module brake_speed_compare (
    input wire logic hclk,
    input wire logic hresetn,
    brake_seq_if.cmp cif
);
    // strictly lower; a threshold of zero never reports below
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cif.below <= 1'b0;
        end else begin
            cif.below <= (cif.speed < cif.threshold);
        end
    end
endmodule : brake_speed_compare
`default_nettype wire

// ### hw/holding_brake_sequencer.sv
// holding-brake release sequencer with AHB-Lite settings slave
//
// Behaviour
// - release output low locks, high frees motor
// - separate programmable on and off delays
// - engage when off-delay expires, regardless of speed
// - engage early once speed below threshold
// - engage brake only after servo is off
`timescale 1ns/1ps
`default_nettype none
module holding_brake_sequencer #(
    parameter int TICK_CYCLES = brake_pkg::TICK_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic servo_enable_in,
    input wire logic [15:0] motor_speed,
    output logic brake_release_out
);
    brake_seq_if sif ();

    brake_pkg::brake_state_e state;
    logic [15:0] on_delay_setting;
    logic [15:0] off_delay_setting;
    logic [15:0] zero_speed_threshold;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic start;
    logic [15:0] start_setting;

    // decode shared by the write and read paths
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // only the three settings words hold written data
    function automatic logic is_setting(input logic [11:0] a);
        is_setting = hit(a, brake_pkg::ON_DELAY_OFS) ||
            hit(a, brake_pkg::OFF_DELAY_OFS) ||
            hit(a, brake_pkg::SPEED_THR_OFS);
    endfunction : is_setting

    function automatic logic [31:0] status_word(
        input logic rel, input logic srv, input logic blw,
        input brake_pkg::brake_state_e st);
        logic [31:0] w;
        w = 32'h00000000;
        w[brake_pkg::STAT_RELEASE_BIT] = rel;
        w[brake_pkg::STAT_SERVO_BIT] = srv;
        w[brake_pkg::STAT_BELOW_BIT] = blw;
        w[brake_pkg::STAT_STATE_LSB +: 2] = st;
        status_word = w;
    endfunction : status_word

    wire logic addr_phase = hsel && htrans[1] && hready;

    brake_delay_timer #(
        .TICKS(TICK_CYCLES)
    ) u_timer (
        .hclk(hclk),
        .hresetn(hresetn),
        .tif(sif.timer)
    );

    brake_speed_compare u_cmp (
        .hclk(hclk),
        .hresetn(hresetn),
        .cif(sif.cmp)
    );

    assign sif.start = start;
    assign sif.setting = start_setting;
    assign sif.speed = motor_speed;
    assign sif.threshold = zero_speed_threshold;

    // zero-wait slave: never stretches, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // write address captured in the address phase, data used next cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
        end else begin
            wr_pend <= addr_phase && hwrite;
            wr_addr <= haddr[11:0];
        end
    end

    // settings registers; unmapped writes are dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            on_delay_setting <= brake_pkg::ON_DELAY_RST;
            off_delay_setting <= brake_pkg::OFF_DELAY_RST;
            zero_speed_threshold <= brake_pkg::SPEED_THR_RST;
        end else if (wr_pend) begin
            if (hit(wr_addr, brake_pkg::ON_DELAY_OFS)) begin
                on_delay_setting <= hwdata[15:0];
            end
            if (hit(wr_addr, brake_pkg::OFF_DELAY_OFS)) begin
                off_delay_setting <= hwdata[15:0];
            end
            if (hit(wr_addr, brake_pkg::SPEED_THR_OFS)) begin
                zero_speed_threshold <= hwdata[15:0];
            end
        end
    end

    // read data sampled in the address phase so hrdata is a flop;
    // a write to the same word just before is forwarded from hwdata
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (addr_phase && !hwrite) begin
            if (wr_pend && wr_addr == haddr[11:0] &&
                is_setting(haddr[11:0])) begin
                hrdata <= {16'h0000, hwdata[15:0]};
            end else if (hit(haddr[11:0], brake_pkg::ON_DELAY_OFS)) begin
                hrdata <= {16'h0000, on_delay_setting};
            end else if (hit(haddr[11:0], brake_pkg::OFF_DELAY_OFS)) begin
                hrdata <= {16'h0000, off_delay_setting};
            end else if (hit(haddr[11:0], brake_pkg::SPEED_THR_OFS)) begin
                hrdata <= {16'h0000, zero_speed_threshold};
            end else if (hit(haddr[11:0], brake_pkg::STATUS_OFS)) begin
                hrdata <= status_word(brake_release_out, servo_enable_in,
                                      sif.below, state);
            end else begin
                hrdata <= 32'h00000000;
            end
        end
    end

    // timer start: one pulse when a delay phase is entered
    always_comb begin
        start = 1'b0;
        start_setting = on_delay_setting;
        unique case (state)
            brake_pkg::ENGAGED: begin
                start = servo_enable_in;
            end
            brake_pkg::RELEASED: begin
                start = !servo_enable_in;
                start_setting = off_delay_setting;
            end
            brake_pkg::ON_WAIT, brake_pkg::OFF_WAIT: begin
                start = 1'b0;
            end
        endcase
    end

    // brake sequence; the output changes with the state transition.
    // servo re-enabled during off-delay keeps the brake free, so the
    // motor is never clamped while the drive may still hold torque
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= brake_pkg::ENGAGED;
            brake_release_out <= 1'b0;
        end else begin
            unique case (state)
                brake_pkg::ENGAGED: begin
                    if (servo_enable_in) begin
                        state <= brake_pkg::ON_WAIT;
                    end
                end
                brake_pkg::ON_WAIT: begin
                    if (!servo_enable_in) begin
                        state <= brake_pkg::ENGAGED;
                    end else if (sif.done) begin
                        state <= brake_pkg::RELEASED;
                        brake_release_out <= 1'b1;
                    end
                end
                brake_pkg::RELEASED: begin
                    if (!servo_enable_in) begin
                        state <= brake_pkg::OFF_WAIT;
                    end
                end
                brake_pkg::OFF_WAIT: begin
                    if (servo_enable_in) begin
                        state <= brake_pkg::RELEASED;
                    end else if (sif.done || sif.below) begin
                        state <= brake_pkg::ENGAGED;
                        brake_release_out <= 1'b0;
                    end
                end
            endcase
        end
    end

    // checks
    sequence off_expired;
        state == brake_pkg::OFF_WAIT && !servo_enable_in && sif.done;
    endsequence

    sequence off_slow;
        state == brake_pkg::OFF_WAIT && !servo_enable_in && sif.below;
    endsequence

    sequence on_wait_done;
        state == brake_pkg::ON_WAIT && servo_enable_in && sif.done;
    endsequence

    sequence on_reg_write;
        wr_pend && wr_addr == brake_pkg::ON_DELAY_OFS;
    endsequence

    AST_LOCKED_WHEN_ENGAGED: assert property (
        @(posedge hclk) disable iff (!hresetn)
        state == brake_pkg::ENGAGED |-> !brake_release_out)
        else $error("release output high while engaged");

    AST_ON_SETTING_STORED: assert property (
        @(posedge hclk) disable iff (!hresetn)
        on_reg_write |=> on_delay_setting == $past(hwdata[15:0]))
        else $error("on-delay setting not stored");

    AST_OFF_EXPIRY_ENGAGES: assert property (
        @(posedge hclk) disable iff (!hresetn)
        off_expired |=> !brake_release_out && state == brake_pkg::ENGAGED)
        else $error("brake not engaged at off-delay expiry");

    AST_SLOW_ENGAGES: assert property (
        @(posedge hclk) disable iff (!hresetn)
        off_slow |=> !brake_release_out)
        else $error("brake not engaged below speed threshold");

    AST_ENGAGE_AFTER_SERVO_OFF: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $fell(brake_release_out) |-> !$past(servo_enable_in, 1))
        else $error("brake engaged while servo enabled");

    AST_RELEASE_AFTER_ON_DELAY: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(brake_release_out) |-> $past(state) == brake_pkg::ON_WAIT
            && $past(sif.done))
        else $error("release without on-delay expiry");

    AST_ON_DONE_RELEASES: assert property (
        @(posedge hclk) disable iff (!hresetn)
        on_wait_done |=> brake_release_out ##1 brake_release_out
            || !servo_enable_in)
        else $error("release missing after on-delay");

    AST_ENABLE_STARTS_TIMER: assert property (
        @(posedge hclk) disable iff (!hresetn)
        state == brake_pkg::ENGAGED && servo_enable_in
            |=> state == brake_pkg::ON_WAIT && !brake_release_out)
        else $error("servo enable did not start on-delay");

    sequence servo_dropped;
        state == brake_pkg::RELEASED && !servo_enable_in;
    endsequence

    // the drive may still hold torque, so the output stays high through
    // the whole off-delay window until expiry or low speed ends it
    AST_FREE_DURING_OFF_WAIT: assert property (
        @(posedge hclk) disable iff (!hresetn)
        state == brake_pkg::OFF_WAIT |-> brake_release_out)
        else $error("brake engaged before off-delay ended");

    AST_LOCKED_DURING_ON_WAIT: assert property (
        @(posedge hclk) disable iff (!hresetn)
        state == brake_pkg::ON_WAIT |-> !brake_release_out)
        else $error("brake released before on-delay ended");

    AST_RELEASE_ONLY_WHEN_FREE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        brake_release_out |-> state == brake_pkg::RELEASED
            || state == brake_pkg::OFF_WAIT)
        else $error("release output high outside free states");

    AST_SERVO_OFF_STARTS_OFF_WAIT: assert property (
        @(posedge hclk) disable iff (!hresetn)
        servo_dropped |=> state == brake_pkg::OFF_WAIT && brake_release_out)
        else $error("servo off did not start off-delay");

    AST_REENABLE_KEEPS_FREE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        state == brake_pkg::OFF_WAIT && servo_enable_in
            |=> state == brake_pkg::RELEASED && brake_release_out)
        else $error("re-enable during off-delay engaged brake");

    AST_OFF_SETTING_STORED: assert property (
        @(posedge hclk) disable iff (!hresetn)
        wr_pend && wr_addr == brake_pkg::OFF_DELAY_OFS
            |=> off_delay_setting == $past(hwdata[15:0]))
        else $error("off-delay setting not stored");

    AST_BELOW_TRACKS_SPEED: assert property (
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> sif.below == ($past(motor_speed)
            < $past(zero_speed_threshold)))
        else $error("speed compare out of step with inputs");
endmodule : holding_brake_sequencer
`default_nettype wire

// ### dv/brake_relay.sv
// behavioural relay that powers the holding-brake coil
`timescale 1ns/1ps
`default_nettype none
module brake_relay (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic brake_release_out,
    output logic shaft_locked
);
    // contact follows the coil one cycle late; it never brakes on its own,
    // so it cannot oppose the motor while that decelerates
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shaft_locked <= 1'b1;
        end else begin
            shaft_locked <= !brake_release_out;
        end
    end
endmodule : brake_relay
`default_nettype wire

// ### dv/tb.sv
// self-checking bench of the holding-brake sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    localparam int TK = 4;
    typedef struct {
        logic [15:0] on_ms;
        logic [15:0] off_ms;
        int on_n;
        int off_n;
    } row_s;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, brake_release_out, shaft_locked;
    logic [31:0] hrdata, rd;
    logic servo_enable_in = 1'b0;
    logic [15:0] motor_speed = 16'hFFFF;
    int n_mismatch = 0;
    int compares = 0;
    row_s rows [3] = '{'{16'h0000, 16'h0000, 2, 2},
                       '{16'h0001, 16'h0002, 6, 10},
                       '{16'h0002, 16'h0003, 10, 14}};

    // clock of 25 ns period
    always #12.5 hclk = !hclk;

    holding_brake_sequencer #(.TICK_CYCLES(TK)) dut (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .servo_enable_in(servo_enable_in), .motor_speed(motor_speed),
        .brake_release_out(brake_release_out));
    brake_relay relay (.hclk(hclk), .hresetn(hresetn),
        .brake_release_out(brake_release_out), .shaft_locked(shaft_locked));

    // one single word transfer; waits on hready, never on a fixed count
    task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK(hresp, 1'b0)
    endtask : bus

    task servo(input logic v);
        @(posedge hclk);
        servo_enable_in <= v;
    endtask : servo

    // output holds b until the n-th edge after the drive, then shows a
    task edge_check(input int n, input logic b, input logic a);
        repeat (n - 1) @(posedge hclk);
        #1 `CHK(brake_release_out, b)
        @(posedge hclk);
        #1 `CHK(brake_release_out, a)
    endtask : edge_check

    task hold_check(input int n, input logic v);
        repeat (n) begin
            @(posedge hclk);
            #1 `CHK(brake_release_out, v)
        end
    endtask : hold_check

    task summarize;
        $display("counts: compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge hclk);
        n_mismatch++;
        summarize;
    end

    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        #1 `CHK(brake_release_out, 1'b0)
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 12'(4 * i), 32'h0);
            `CHK(rd, 32'h0)
        end
        bus(1'b1, 12'h010, 32'h0000_FFFF);
        bus(1'b0, 12'h010, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, brake_pkg::SPEED_THR_OFS, 32'h0000_0010);
        $display("test reset and map done");
        // timing rows with the motor still fast
        foreach (rows[i]) begin
            bus(1'b1, brake_pkg::ON_DELAY_OFS, {16'h0, rows[i].on_ms});
            bus(1'b0, brake_pkg::ON_DELAY_OFS, 32'h0);
            `CHK(rd, {16'h0, rows[i].on_ms})
            bus(1'b1, brake_pkg::OFF_DELAY_OFS, {16'h0, rows[i].off_ms});
            bus(1'b0, brake_pkg::OFF_DELAY_OFS, 32'h0);
            `CHK(rd, {16'h0, rows[i].off_ms})
            servo(1'b1);
            edge_check(rows[i].on_n, 1'b0, 1'b1);
            @(posedge hclk);
            #1 `CHK(shaft_locked, 1'b0)
            bus(1'b0, brake_pkg::STATUS_OFS, 32'h0);
            `CHK(rd, 32'h0000_0013)
            servo(1'b0);
            edge_check(rows[i].off_n, 1'b1, 1'b0);
            $display("test row %0d done", i);
        end
        // enable dropped during on-wait must never release
        bus(1'b1, brake_pkg::ON_DELAY_OFS, 32'h0000_0002);
        servo(1'b1);
        repeat (3) @(posedge hclk);
        servo(1'b0);
        hold_check(12, 1'b0);
        $display("test abort on-wait done");
        // early engage once speed falls under the threshold
        servo(1'b1);
        edge_check(10, 1'b0, 1'b1);
        servo(1'b0);
        repeat (4) @(posedge hclk);
        @(posedge hclk);
        motor_speed <= 16'h000F;
        edge_check(2, 1'b1, 1'b0);
        bus(1'b0, brake_pkg::STATUS_OFS, 32'h0);
        `CHK(rd, 32'h0000_0004)
        $display("test early engage done");
        // servo back during off-wait keeps the brake free
        motor_speed <= 16'h0010;
        servo(1'b1);
        edge_check(10, 1'b0, 1'b1);
        servo(1'b0);
        repeat (4) @(posedge hclk);
        servo(1'b1);
        hold_check(20, 1'b1);
        $display("test re-enable done");
        summarize;
    end
endmodule : tb
`default_nettype wire
